// >>> src/gpio_port_pkg.sv
// Shared constants and carrier types for the general digital I/O port block
package gpio_port_pkg;

  localparam int PORT_WIDTH      = 8;
  localparam int NUM_PORTS       = 3;
  localparam int BIT_INDEX_WIDTH = 3;

  typedef logic [PORT_WIDTH-1:0] port_byte_t;

  // Reset values of the software-visible locations and the single-bit mask
  localparam port_byte_t DRIVE_VALUE_RESET = 8'h00;
  localparam port_byte_t DIRECTION_RESET   = 8'h00;
  localparam port_byte_t PIN_INPUT_RESET   = 8'h00;
  localparam port_byte_t READ_DATA_RESET   = 8'h00;
  localparam port_byte_t SINGLE_BIT        = 8'h01;

  // Per-port access strobes, shared by all pins of one port
  typedef struct packed {
    logic drive_value_write_strobe;
    logic direction_write_strobe;
    logic drive_value_read_strobe;
    logic direction_read_strobe;
    logic pin_input_read_strobe;
  } port_strobe_t;

  // Single-bit modifier that accompanies a write strobe
  typedef struct packed {
    logic                       set_io_bit_instruction;
    logic                       clear_io_bit_instruction;
    logic [BIT_INDEX_WIDTH-1:0] bit_index;
  } bit_op_t;

  // Alternate peripheral takeover of individual pins
  typedef struct packed {
    port_byte_t enable;
    port_byte_t output_enable;
    port_byte_t output_value;
  } alt_override_t;

  // What one port presents to its pads
  typedef struct packed {
    port_byte_t out_value;
    port_byte_t oe_n;
    port_byte_t pullup_en;
  } pad_drive_t;

endpackage : gpio_port_pkg

// >>> src/general_digital_io_port.sv
// General digital I/O ports: direction, drive value, pull-up and synchronised pin input
//
// Function
// R01: A set direction bit makes its pin an output, a cleared one makes it an input.
// R02: An input pin with its drive value bit at one gets a pull-up unless pull-ups are disabled.
// R03: An output pin is driven high for drive value one and low for zero, with no pull-up.
// R04: Reset tri-states every pin at once, with no clock needed.
// R05: The global pull-up disable removes the pull-up from every pin of every port.
// R06: Each port has drive value, direction and pin input locations; pin input is read-only.
// R07: Single-bit set and clear touch only the addressed pin of the addressed location.
// R08: The pin input bit always shows the pad level through a latch and a register; the code reads zero on pins clamped by sleep_clamp.
// R09: The latch is open while the clock is high and its value is registered at the next rise.
// R10: A pad transition reaches the pin input register within one half to one and a half periods.
// R11: A written value reaches the pin input register one period later, so software waits once.
// R12: Software passes through pull-up input or output low between tri-state and output high.
// R13: Software passes through tri-state or output high between pull-up input and output low.
// R14: Alternate functions on some pins leave the other pins of the port as plain I/O.
// R15: Strobes are shared per port; clock, sleep clamp and pull-up disable by all ports.
// R16: In deep sleep each digital input is clamped low unless it serves as an external interrupt.
// R17: After reset the direction and drive value registers read zero.
module general_digital_io_port (
  input  wire logic                                                sys_clk,
  input  wire logic                                                reset,
  input  wire logic                                                clk_en,
  input  wire gpio_port_pkg::port_strobe_t [gpio_port_pkg::NUM_PORTS-1:0]  port_strobe,
  input  wire gpio_port_pkg::port_byte_t                           write_data,
  input  wire gpio_port_pkg::bit_op_t                              bit_op,
  input  wire logic                                                global_pullup_disable,
  input  wire logic                                                sleep_clamp,
  input  wire gpio_port_pkg::port_byte_t [gpio_port_pkg::NUM_PORTS-1:0]    ext_int_enable,
  input  wire gpio_port_pkg::alt_override_t [gpio_port_pkg::NUM_PORTS-1:0] alt_override,
  input  wire gpio_port_pkg::port_byte_t [gpio_port_pkg::NUM_PORTS-1:0]    pad_in,
  output gpio_port_pkg::pad_drive_t [gpio_port_pkg::NUM_PORTS-1:0]         pad_drive,
  output gpio_port_pkg::port_byte_t [gpio_port_pkg::NUM_PORTS-1:0]         alt_digital_input,
  output gpio_port_pkg::port_byte_t                                read_data
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage

  gpio_port_pkg::port_byte_t drive_reg  [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t drive_next [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t dir_reg    [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t dir_next   [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t pin_reg    [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t digital_in [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t clamp_mask [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t port_read  [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t pad_oe_n   [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t pad_value  [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t pad_pullup [gpio_port_pkg::NUM_PORTS];
  gpio_port_pkg::port_byte_t read_reg;
  gpio_port_pkg::port_byte_t read_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Write path

  // A plain write replaces the byte; set or clear alters one bit only
  function automatic gpio_port_pkg::port_byte_t apply_write(
    input gpio_port_pkg::port_byte_t old_value,
    input gpio_port_pkg::port_byte_t data,
    input gpio_port_pkg::bit_op_t    op
  );
    gpio_port_pkg::port_byte_t mask;
    mask = gpio_port_pkg::SINGLE_BIT << op.bit_index;
    if (op.set_io_bit_instruction)
    begin
      apply_write = old_value | mask; // [R07]
    end
    else if (op.clear_io_bit_instruction)
    begin
      apply_write = old_value & ~mask; // [R07]
    end
    else
    begin
      apply_write = data;
    end
  endfunction : apply_write

  always_comb
  begin
    for (int p = 0; p < gpio_port_pkg::NUM_PORTS; p++)
    begin
      drive_next[p] = drive_reg[p];
      dir_next[p]   = dir_reg[p];
      if (port_strobe[p].drive_value_write_strobe) // [R15]
      begin
        drive_next[p] = apply_write(drive_reg[p], write_data, bit_op); // [R06]
      end
      if (port_strobe[p].direction_write_strobe)
      begin
        dir_next[p] = apply_write(dir_reg[p], write_data, bit_op); // [R06]
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int p = 0; p < gpio_port_pkg::NUM_PORTS; p++)
      begin
        drive_reg[p] <= gpio_port_pkg::DRIVE_VALUE_RESET; // [R17]
        dir_reg[p]   <= gpio_port_pkg::DIRECTION_RESET; // [R17]
      end
    end
    else if (clk_en)
    begin
      for (int p = 0; p < gpio_port_pkg::NUM_PORTS; p++)
      begin
        drive_reg[p] <= drive_next[p];
        dir_reg[p]   <= dir_next[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pad drive

  // One pad controller per port; all share reset and the pull-up disable
  for (genvar g = 0; g < gpio_port_pkg::NUM_PORTS; g++)
  begin : g_pad
    pad_control #(
      .WIDTH (gpio_port_pkg::PORT_WIDTH)
    ) u_pad_control (
      .reset                 (reset),
      .global_pullup_disable (global_pullup_disable),
      .dir_value             (dir_reg[g]),
      .drive_value           (drive_reg[g]),
      .alt_enable            (alt_override[g].enable),
      .alt_output_enable     (alt_override[g].output_enable),
      .alt_output_value      (alt_override[g].output_value),
      .oe_n                  (pad_oe_n[g]),
      .out_value             (pad_value[g]),
      .pullup_en             (pad_pullup[g])
    );
  end

  always_comb
  begin
    for (int p = 0; p < gpio_port_pkg::NUM_PORTS; p++)
    begin
      pad_drive[p].out_value = pad_value[p];
      pad_drive[p].oe_n      = pad_oe_n[p];
      pad_drive[p].pullup_en = pad_pullup[p];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input path

  // Clamp keeps floating pads from burning power in deep sleep
  always_comb
  begin
    for (int p = 0; p < gpio_port_pkg::NUM_PORTS; p++)
    begin
      clamp_mask[p]        = {gpio_port_pkg::PORT_WIDTH{sleep_clamp}} & ~ext_int_enable[p]; // [R16]
      digital_in[p]        = pad_in[p] & ~clamp_mask[p];
      alt_digital_input[p] = digital_in[p];
    end
  end

  for (genvar g = 0; g < gpio_port_pkg::NUM_PORTS; g++)
  begin : g_sync
    pin_input_sync #(
      .WIDTH (gpio_port_pkg::PORT_WIDTH)
    ) u_pin_sync (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .clk_en    (clk_en),
      .pad_level (digital_in[g]),
      .pin_value (pin_reg[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  // Strobes of several locations at once are ORed; the CPU never issues that
  always_comb
  begin
    for (int p = 0; p < gpio_port_pkg::NUM_PORTS; p++)
    begin
      port_read[p] = '0;
      if (port_strobe[p].drive_value_read_strobe)
      begin
        port_read[p] = port_read[p] | drive_reg[p]; // [R06]
      end
      if (port_strobe[p].direction_read_strobe)
      begin
        port_read[p] = port_read[p] | dir_reg[p]; // [R06]
      end
      if (port_strobe[p].pin_input_read_strobe)
      begin
        port_read[p] = port_read[p] | pin_reg[p]; // [R08]
      end
    end
  end

  // Idle ports answer zero, so a plain OR merges the ports
  always_comb
  begin
    read_next = '0;
    for (int p = 0; p < gpio_port_pkg::NUM_PORTS; p++)
    begin
      read_next = read_next | port_read[p];
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      read_reg <= gpio_port_pkg::READ_DATA_RESET;
    end
    else if (clk_en)
    begin
      read_reg <= read_next;
    end
  end

  assign read_data = read_reg;

endmodule : general_digital_io_port

////////////////////////////////////////////////////////////////////////////////
// Pad control of one port: direction, level and pull-up per pin

module pad_control #(
  parameter int WIDTH = 8
) (
  input  wire logic             reset,
  input  wire logic             global_pullup_disable,
  input  wire logic [WIDTH-1:0] dir_value,
  input  wire logic [WIDTH-1:0] drive_value,
  input  wire logic [WIDTH-1:0] alt_enable,
  input  wire logic [WIDTH-1:0] alt_output_enable,
  input  wire logic [WIDTH-1:0] alt_output_value,
  output logic      [WIDTH-1:0] oe_n,
  output logic      [WIDTH-1:0] out_value,
  output logic      [WIDTH-1:0] pullup_en
);

  logic [WIDTH-1:0] oe;

  // Alternate takeover is per pin, so untouched pins keep plain port control
  always_comb
  begin
    oe        = (alt_enable & alt_output_enable) | (~alt_enable & dir_value); // [R01] [R14]
    out_value = (alt_enable & alt_output_value) | (~alt_enable & drive_value); // [R03] [R14]
    if (reset)
    begin
      // Reset gates the enables directly so the pads float even without a clock
      oe_n      = '1; // [R04]
      pullup_en = '0; // [R04]
    end
    else if (global_pullup_disable)
    begin
      oe_n      = ~oe;
      pullup_en = '0; // [R05] [R15]
    end
    else
    begin
      oe_n      = ~oe;
      pullup_en = ~oe & drive_value & ~alt_enable; // [R02]
    end
  end

endmodule : pad_control

////////////////////////////////////////////////////////////////////////////////
// Two-stage pin synchroniser: a latch open while the clock is high, then a register

module pin_input_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] pad_level,
  output logic      [WIDTH-1:0] pin_value
);

  logic [WIDTH-1:0] sync_latch;
  logic [WIDTH-1:0] pin_reg;
  logic [WIDTH-1:0] pin_next;

  // Only pin_reg reads the latch; it holds while the clock is low
  always_latch
  begin
    if (sys_clk)
    begin
      sync_latch <= pad_level; // [R09]
    end
  end

  always_comb
  begin
    pin_next = sync_latch; // [R08] [R10] [R11]
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_reg <= WIDTH'(gpio_port_pkg::PIN_INPUT_RESET);
    end
    else if (clk_en)
    begin
      pin_reg <= pin_next; // [R09]
    end
  end

  assign pin_value = pin_reg;

endmodule : pin_input_sync

// >>> verification/general_digital_io_port_monitor.sv
// Checker that watches port 0 of the I/O port block at its ports
module gdio_monitor (
  input wire logic                              sys_clk,
  input wire logic                              reset,
  input wire logic                              clk_en,
  input wire gpio_port_pkg::port_strobe_t [2:0] port_strobe,
  input wire logic [7:0]                        write_data,
  input wire gpio_port_pkg::bit_op_t            bit_op,
  input wire logic                              global_pullup_disable,
  input wire logic [2:0][7:0]                   pad_in,
  input wire gpio_port_pkg::pad_drive_t [2:0]   pad_drive,
  input wire logic [7:0]                        read_data
);
  wire [4:0] s  = port_strobe[0];
  wire [7:0] oe = pad_drive[0].oe_n;
  wire [7:0] pu = pad_drive[0].pullup_en;
  wire [2:0] ix = bit_op.bit_index;
  // Full byte writes only; bit operations have checks of their own
  wire       wr = clk_en && bit_op[4:3] == 2'b00;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  tristate_reset_a: assert property (disable iff (1'b0)
    reset |-> oe == 8'hff && pu == 8'h00) else $error("pins driven in reset");
  dir_write_a: assert property (s == 5'h08 && wr |=> oe == ~$past(write_data))
    else $error("direction write wrong");
  drive_level_a: assert property (s == 5'h10 && wr
    |=> (pad_drive[0].out_value & ~oe) == ($past(write_data) & ~oe)) else $error("bad level");
  pullup_a: assert property (s == 5'h10 && wr
    |=> pu == ($past(write_data) & oe & {8{!global_pullup_disable}})) else $error("bad pull-up");
  pud_a: assert property (global_pullup_disable |-> pu == 8'h00)
    else $error("pull-up while disabled");
  bit_set_a: assert property (s == 5'h08 && clk_en && bit_op[4]
    |=> oe == ($past(oe) & ~(8'h01 << $past(ix)))) else $error("bit set spread");
  bit_clear_a: assert property (s == 5'h10 && clk_en && bit_op[4:3] == 2'b01
    && !global_pullup_disable |=> global_pullup_disable
    || pu == ($past(pu) & ~(8'h01 << $past(ix)))) else $error("bit clear spread");
  pin_sync_a: assert property (s == 5'h01 && clk_en && $past(clk_en) && !$past(reset)
    && $stable(pad_in[0]) && $past(pad_in[0]) == $past(pad_in[0], 2)
    |=> read_data == $past(pad_in[0])) else $error("pin input not synchronised");
endmodule : gdio_monitor
bind general_digital_io_port gdio_monitor u_mon (.sys_clk, .reset, .clk_en, .port_strobe,
  .write_data, .bit_op, .global_pullup_disable, .pad_in, .pad_drive, .read_data);

// >>> verification/gpio_pad_model.sv
// Pad model: resolves each pin from the block's drive, outside drivers and pull-ups
module gpio_pad_model (
  input  wire logic                            sys_clk,
  input  wire gpio_port_pkg::pad_drive_t [2:0] pad_drive,
  input  wire logic [2:0][7:0]                 ext_en,
  input  wire logic [2:0][7:0]                 ext_val,
  output      logic [2:0][7:0]                 pad_in
);
  // A floating pin flips every cycle so that no steady guess can pass
  logic [7:0] noise = 8'h5a;
  always @(posedge sys_clk) noise <= ~noise;
  always_comb
    for (int p = 0; p < 3; p++)
      pad_in[p] = ~pad_drive[p].oe_n & pad_drive[p].out_value
        | pad_drive[p].oe_n & (ext_en[p] & ext_val[p]
        | ~ext_en[p] & (pad_drive[p].pullup_en | noise));
endmodule : gpio_pad_model

// >>> verification/general_digital_io_port_tb_top.sv
// Self-checking bench: port 0 register operations, loopback through the pad model
`define CHK(a, e) \
  begin total_checks++; if ((a) !== (e)) \
  begin errors++; $display("BAD %0t got %h want %h", $time, a, e); end end
module general_digital_io_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [4:0] s, op; logic [7:0] wd, oe, pu, rd;} row_t;
  logic                              sys_clk = 0, reset = 1, clk_en = 1;
  logic                              global_pullup_disable = 0;
  int                                errors = 0, total_checks = 0;
  gpio_port_pkg::port_strobe_t [2:0] ps = '0;
  gpio_port_pkg::bit_op_t            op = '0;
  logic [7:0]                        wd = '0, rd;
  logic [2:0][7:0]                   ext_en = '0, ext_val = '0, pad_in;
  gpio_port_pkg::pad_drive_t [2:0]   pad_drive;
  logic                              sleep_clamp = 0;
  logic [2:0][7:0]                   int_en = '0, alt_din;
  gpio_port_pkg::alt_override_t [2:0] alt = '0;
  // Strobe, bit op, data, then expected enables, pull-ups and read answer
  row_t rows [12] = '{
    '{5'h10, 5'h00, 8'hf0, 8'hff, 8'hf0, 8'h00},
    '{5'h08, 5'h00, 8'h3c, 8'hc3, 8'hc0, 8'h00},
    '{5'h10, 5'h10, 8'h00, 8'hc3, 8'hc1, 8'h00},
    '{5'h08, 5'h0d, 8'h00, 8'he3, 8'he1, 8'h00},
    '{5'h04, 5'h00, 8'h00, 8'he3, 8'he1, 8'hf1},
    '{5'h02, 5'h00, 8'h00, 8'he3, 8'he1, 8'h1c},
    '{5'h10, 5'h11, 8'h00, 8'he3, 8'he3, 8'h00},
    '{5'h08, 5'h11, 8'h00, 8'he1, 8'he1, 8'h00},
    '{5'h08, 5'h16, 8'h00, 8'ha1, 8'ha1, 8'h00},
    '{5'h10, 5'h0e, 8'h00, 8'ha1, 8'ha1, 8'h00},
    '{5'h10, 5'h1a, 8'h00, 8'ha1, 8'ha1, 8'h00},
    '{5'h04, 5'h00, 8'h00, 8'ha1, 8'ha1, 8'hb7}
  };
  general_digital_io_port dut (.sys_clk, .reset, .clk_en, .port_strobe(ps), .write_data(wd),
    .bit_op(op), .global_pullup_disable, .sleep_clamp, .ext_int_enable(int_en),
    .alt_override(alt), .pad_in, .pad_drive, .alt_digital_input(alt_din), .read_data(rd));
  gpio_pad_model pads (.sys_clk, .pad_drive, .ext_en, .ext_val, .pad_in);
  always #50 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic run(row_t r);
    @(posedge sys_clk);
    ps[0] <= r.s;
    op <= r.op;
    wd <= r.wd;
    @(posedge sys_clk);
    ps[0] <= '0;
    #1;
    `CHK(pad_drive[0].oe_n, r.oe)
    `CHK(pad_drive[0].pullup_en, r.pu)
    `CHK(rd, r.rd)
  endtask : run
  initial
  begin
    repeat (400) @(posedge sys_clk);
    errors++;
    close_out();
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 0;
    foreach (rows[i]) run(rows[i]);
    @(posedge sys_clk);
    ext_en[0] <= 8'ha1;
    repeat (3) @(posedge sys_clk);
    ps[0] <= 5'h10;
    wd <= 8'h0f;
    // Read right behind the write: first answer still shows the old pins
    @(posedge sys_clk);
    ps[0] <= 5'h01;
    @(posedge sys_clk);
    #1 `CHK(rd, 8'h16)
    @(posedge sys_clk);
    #1 `CHK(rd, 8'h0e)
    @(posedge sys_clk);
    ps[0] <= '0;
    global_pullup_disable <= 1;
    @(posedge sys_clk);
    #1 `CHK(pad_drive[0].pullup_en, 8'h00)
    global_pullup_disable <= 0;
    // One pin taken over by a peripheral; its neighbours stay plain port pins
    @(posedge sys_clk);
    alt[0] <= '{8'h01, 8'h01, 8'h00};
    @(posedge sys_clk);
    #1 `CHK(pad_drive[0].oe_n, 8'ha0)
    `CHK(pad_drive[0].pullup_en, 8'h00)
    `CHK(pad_drive[0].out_value, 8'h0e)
    @(posedge sys_clk);
    alt[0] <= '0;
    sleep_clamp <= 1;
    int_en[0] <= 8'h02;
    @(posedge sys_clk);
    #1 `CHK(alt_din[0], 8'h02)
    // Port 1 has strobes of its own; a frozen clock enable ignores a strobe
    @(posedge sys_clk);
    sleep_clamp <= 0;
    ps[1] <= 5'h08;
    wd <= 8'hff;
    @(posedge sys_clk);
    ps[1] <= '0;
    #1 `CHK(pad_drive[1].oe_n, 8'h00)
    `CHK(pad_drive[0].oe_n, 8'ha1)
    @(posedge sys_clk);
    clk_en <= 0;
    ps[0] <= 5'h08;
    @(posedge sys_clk);
    ps[0] <= '0;
    clk_en <= 1;
    #1 `CHK(pad_drive[0].oe_n, 8'ha1)
    // Reset lands between edges: pins must let go without a clock
    #20 reset = 1;
    #1 `CHK(pad_drive[0].oe_n, 8'hff)
    @(posedge sys_clk);
    reset <= 0;
    run(row_t'{5'h02, 5'h00, 8'h00, 8'hff, 8'h00, 8'h00});
    run(row_t'{5'h04, 5'h00, 8'h00, 8'hff, 8'h00, 8'h00});
    close_out();
  end
endmodule : general_digital_io_port_tb_top
